// [verilog/irs_defines.vh]
// constants of the infrared port interrupt status / fifo control block
// assumes an apb slave with 32-bit data and a 10 MHz reference clock
// Summary of operation
// - legacy bits 7:6 mirror fifo enable
// - legacy bits 5:4 always read zero
// - bit 3 zero unless fifo timeout pending
// - bit 0 high when nothing pending
// - timeout after four idle character times
// - line status, then data, then tx empty
// - data ready clears by read or level
// - timer flag when enabled timer hits zero
// - frame status flag follows its fifo level
// - tx threshold flag while fifo below level
// - dma terminal count sets, status read clears
// - handshake toggle sets, handshake read clears
// - line error sets bit 2, line status read clears
// - frame end sets bit 2 in fast modes
// - tx empty when fifo and shifter empty
// - rx threshold at level or on timeout
// - rx trigger codes give 1,4,8,14 bytes
// - bit 3 selects dma mode one with fifo
// - bit 2 clears tx fifo, self clearing
// - bit 1 clears rx fifo, self clearing
// - bit 0 enables fifo mode first
// - 32-byte fifo rx levels 1,4,16,26 in advanced mode
// - tx levels 1,3,9,13 or 1,7,17,25
`ifndef IRS_DEFINES_VH
`define IRS_DEFINES_VH
// register byte addresses (printed offset 2 is an index)
`define IRS_IDX_STATUS      2
`define IRS_ADDR_STATUS     8'h08
`define IRS_ADDR_IRQ_EN     8'h04
`define IRS_ADDR_CONFIG     8'h20
// reset values
`define IRS_STATUS_RESET    8'h22
`define IRS_FIFOCTL_RESET   8'h00
`define IRS_IRQ_EN_RESET    8'h00
`define IRS_CONFIG_RESET    8'h00
// fifo control field positions
`define IRS_FC_RXTRIG_HI    7
`define IRS_FC_RXTRIG_LO    6
`define IRS_FC_TXTRIG_HI    5
`define IRS_FC_TXTRIG_LO    4
`define IRS_FC_DMA_MODE     3
`define IRS_FC_TXCLR        2
`define IRS_FC_RXCLR        1
`define IRS_FC_FIFO_EN      0
// config field positions
`define IRS_CF_ADVANCED     0
`define IRS_CF_FIFO32       1
`define IRS_CF_FASTRATE     2
`define IRS_CF_HS_ENABLE    3
// timeout: four character times
`define IRS_TIMEOUT_CHARS   3'h4
// legacy identification codes (bits 3:0)
`define IRS_ID_NONE         4'h1
`define IRS_ID_LINE         4'h6
`define IRS_ID_DATA         4'h4
`define IRS_ID_TIMEOUT      4'hC
`define IRS_ID_TXEMPTY      4'h2
`endif

// [verilog/irs_status_fifo_ctrl.v]
// interrupt status / fifo control block of an infrared serial port
// assumes surrounding port logic supplies fifo levels and event pulses
// on the reference clock; pin-level inputs are synchronised here
`timescale 1ns/1ns
`include "irs_defines.vh"

module irs_status_fifo_ctrl
(
    // clock and reset
    input  wire        I_REF_CLK,
    input  wire        I_RESETN,
    // apb slave
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [7:0]  I_PADDR,
    input  wire [31:0] I_PWDATA,
    output wire [31:0] O_PRDATA,
    output wire        O_PREADY,
    output wire        O_PSLVERR,
    // port datapath state (same clock)
    input  wire [5:0]  I_RX_LEVEL,
    input  wire [5:0]  I_TX_LEVEL,
    input  wire        I_TX_SHIFT_EMPTY,
    input  wire        I_CHAR_TICK,
    input  wire        I_RX_BUFFER_READ,
    input  wire        I_TX_BUFFER_WRITE,
    input  wire        I_LINE_STATUS_READ,
    input  wire        I_HANDSHAKE_STATUS_READ,
    input  wire        I_LINE_ERROR,
    input  wire        I_FRAME_END,
    input  wire        I_TIMER_ZERO,
    input  wire        I_TIMER_RUN,
    input  wire        I_FS_AT_THRESHOLD,
    input  wire        I_FS_TIMEOUT,
    input  wire        I_HANDSHAKE_TOGGLE,
    // dma terminal count pin (asynchronous)
    input  wire        I_DMA_TC,
    // fifo control outputs
    output wire        O_TX_QUEUE_CLEAR,
    output wire        O_RX_QUEUE_CLEAR,
    output wire        O_FIFO_ENABLE,
    output wire        O_DMA_MODE1,
    output wire        O_IRQ
);

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    reg  [1:0] rst_sync_reg;
    reg  [1:0] tc_sync_reg;
    reg        tc_prev_reg;
    wire       rst_n;
    wire       tc_rise;

    assign rst_n   = rst_sync_reg[1];
    assign tc_rise = tc_sync_reg[1] & ~tc_prev_reg;

    always @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    always @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tc_sync_reg <= 2'h0;
            tc_prev_reg <= 1'b0;
        end
        else
        begin
            tc_sync_reg <= {tc_sync_reg[0], I_DMA_TC};
            tc_prev_reg <= tc_sync_reg[1];
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire acc     = I_PSEL & I_PENABLE;
    wire wr      = acc & I_PWRITE;
    wire rd      = acc & ~I_PWRITE;
    wire hit_st  = (I_PADDR == `IRS_ADDR_STATUS);
    wire hit_en  = (I_PADDR == `IRS_ADDR_IRQ_EN);
    wire hit_cf  = (I_PADDR == `IRS_ADDR_CONFIG);
    wire mapped  = hit_st | hit_en | hit_cf;
    wire st_rd   = rd & hit_st;
    wire fc_wr   = wr & hit_st;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    reg  [7:0] fifo_ctl_reg;
    reg  [7:0] irq_en_reg;
    reg  [7:0] config_reg;
    reg        txclr_reg;
    reg        rxclr_reg;

    wire fifo_en  = fifo_ctl_reg[`IRS_FC_FIFO_EN];
    wire adv      = config_reg[`IRS_CF_ADVANCED];
    wire fifo32   = config_reg[`IRS_CF_FIFO32];
    wire fastrate = config_reg[`IRS_CF_FASTRATE];
    wire hs_en    = config_reg[`IRS_CF_HS_ENABLE];

    // other bits only program when the same write sets bit 0
    wire fc_en_now = I_PWDATA[`IRS_FC_FIFO_EN];

    always @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_ctl_reg <= `IRS_FIFOCTL_RESET;
            irq_en_reg   <= `IRS_IRQ_EN_RESET;
            config_reg   <= `IRS_CONFIG_RESET;
            txclr_reg    <= 1'b0;
            rxclr_reg    <= 1'b0;
        end
        else
        begin
            // clear strobes are one cycle; the stored bits read zero
            txclr_reg <= fc_wr & fc_en_now
                         & I_PWDATA[`IRS_FC_TXCLR];
            rxclr_reg <= fc_wr & fc_en_now
                         & I_PWDATA[`IRS_FC_RXCLR];
            if (fc_wr)
            begin
                if (fc_en_now)
                    fifo_ctl_reg <= {I_PWDATA[7:3], 2'b00,
                                     1'b1};
                else
                    fifo_ctl_reg <= `IRS_FIFOCTL_RESET;
            end
            if (wr & hit_en)
                irq_en_reg <= I_PWDATA[7:0];
            if (wr & hit_cf)
                config_reg <= {4'h0, I_PWDATA[3:0]};
        end
    end

    // ------------------------------------------------------------
    // thresholds
    // ------------------------------------------------------------
    reg [5:0] rx_thr;
    reg [5:0] tx_thr;

    always @*
    begin
        case (fifo_ctl_reg[7:6])
            2'h0: rx_thr = 6'h01;
            2'h1: rx_thr = 6'h04;
            2'h2: rx_thr = (adv & fifo32) ? 6'h10 : 6'h08;
            default: rx_thr = (adv & fifo32) ? 6'h1A : 6'h0E;
        endcase
        case (fifo_ctl_reg[5:4])
            2'h0: tx_thr = 6'h01;
            2'h1: tx_thr = fifo32 ? 6'h07 : 6'h03;
            2'h2: tx_thr = fifo32 ? 6'h11 : 6'h09;
            default: tx_thr = fifo32 ? 6'h19 : 6'h0D;
        endcase
    end

    wire rx_at_thr = fifo_en ? (I_RX_LEVEL >= rx_thr)
                             : (I_RX_LEVEL != 6'h00);

    // ------------------------------------------------------------
    // receive time-out: four character ticks with no fifo access
    // ------------------------------------------------------------
    reg  [2:0] to_cnt_reg;
    reg        timeout_reg;

    always @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            to_cnt_reg  <= 3'h0;
            timeout_reg <= 1'b0;
        end
        else if (I_RX_BUFFER_READ | rxclr_reg
                 | (I_RX_LEVEL == 6'h00))
        begin
            to_cnt_reg  <= 3'h0;
            timeout_reg <= 1'b0;
        end
        else if (I_CHAR_TICK & ~timeout_reg)
        begin
            if (to_cnt_reg == (`IRS_TIMEOUT_CHARS - 3'h1))
                timeout_reg <= 1'b1;
            to_cnt_reg <= to_cnt_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // transmit empty edge
    // ------------------------------------------------------------
    // both tx flags set on the edge, not the level, so a clearing
    // read or buffer write is not undone while the queue stays empty
    reg  tx_empty_prev_reg;
    wire tx_all_empty;
    wire tx_empty_rise;

    assign tx_all_empty  = (I_TX_LEVEL == 6'h00) & I_TX_SHIFT_EMPTY;
    assign tx_empty_rise = tx_all_empty & ~tx_empty_prev_reg;

    always @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
            tx_empty_prev_reg <= 1'b1;
        else
            tx_empty_prev_reg <= tx_all_empty;
    end

    // ------------------------------------------------------------
    // sticky flags: set wins over clear
    // ------------------------------------------------------------
    reg timer_flag_reg;
    reg dma_flag_reg;
    reg handshake_flag_reg;
    reg bit2_flag_reg;
    reg tx_empty_flag_reg;
    reg tbr_empty_reg;
    reg line_err_reg;
    reg [7:0] adv_status;
    reg [3:0] legacy_id;
    wire [7:0] status_byte;

    wire tbr_reported = (legacy_id == `IRS_ID_TXEMPTY);

    always @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_flag_reg     <= 1'b0;
            dma_flag_reg       <= 1'b0;
            handshake_flag_reg <= 1'b0;
            bit2_flag_reg      <= 1'b0;
            tx_empty_flag_reg  <= 1'b1;
            tbr_empty_reg      <= 1'b1;
            line_err_reg       <= 1'b0;
        end
        else
        begin
            if (I_TIMER_ZERO & I_TIMER_RUN
                & irq_en_reg[7])
                timer_flag_reg <= 1'b1;
            else if (st_rd)
                timer_flag_reg <= 1'b0;
            if (tc_rise)
                dma_flag_reg <= 1'b1;
            else if (st_rd)
                dma_flag_reg <= 1'b0;
            if (I_HANDSHAKE_TOGGLE & hs_en)
                handshake_flag_reg <= 1'b1;
            else if (I_HANDSHAKE_STATUS_READ | ~hs_en)
                handshake_flag_reg <= 1'b0;
            if (fastrate ? I_FRAME_END : I_LINE_ERROR)
                bit2_flag_reg <= 1'b1;
            else if (fastrate ? st_rd : I_LINE_STATUS_READ)
                bit2_flag_reg <= 1'b0;
            if (tx_empty_rise)
                tx_empty_flag_reg <= 1'b1;
            else if (st_rd & adv)
                tx_empty_flag_reg <= 1'b0;
            if (I_LINE_ERROR)
                line_err_reg <= 1'b1;
            else if (I_LINE_STATUS_READ)
                line_err_reg <= 1'b0;
            if (tx_empty_rise)
                tbr_empty_reg <= 1'b1;
            else if (I_TX_BUFFER_WRITE
                     | (st_rd & ~adv & tbr_reported))
                tbr_empty_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status byte composition
    // ------------------------------------------------------------
    always @*
    begin
        if (line_err_reg)
            legacy_id = `IRS_ID_LINE;
        else if (timeout_reg & fifo_en)
            legacy_id = `IRS_ID_TIMEOUT;
        else if (rx_at_thr | timeout_reg)
            legacy_id = `IRS_ID_DATA;
        else if (tbr_empty_reg)
            legacy_id = `IRS_ID_TXEMPTY;
        else
            legacy_id = `IRS_ID_NONE;
        adv_status = {timer_flag_reg,
                      fastrate & (I_FS_AT_THRESHOLD
                                  | I_FS_TIMEOUT),
                      I_TX_LEVEL < tx_thr,
                      dma_flag_reg,
                      handshake_flag_reg,
                      bit2_flag_reg,
                      tx_empty_flag_reg,
                      (I_RX_LEVEL >= rx_thr) | timeout_reg};
    end

    assign status_byte = adv ? adv_status
                       : {fifo_en, fifo_en,
                          2'b00,
                          legacy_id};

    // ------------------------------------------------------------
    // read data, response and interrupt
    // ------------------------------------------------------------
    reg [31:0] prdata_reg;
    reg        irq_reg;

    wire [7:0] leg_mask = {5'h00, irq_en_reg[2:0]};
    wire [7:0] flags    = adv ? adv_status
                        : {5'h00, line_err_reg,
                           tbr_empty_reg,
                           rx_at_thr | timeout_reg};

    always @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_reg  <= 32'h0000_0000;
            irq_reg     <= 1'b0;
        end
        else
        begin
            // setup-phase sample: data ready by the access edge
            if (I_PSEL & ~I_PENABLE & ~I_PWRITE)
            begin
                if (I_PADDR == `IRS_ADDR_STATUS)
                    prdata_reg <= {24'h0, status_byte};
                else if (I_PADDR == `IRS_ADDR_IRQ_EN)
                    prdata_reg <= {24'h0, irq_en_reg};
                else if (I_PADDR == `IRS_ADDR_CONFIG)
                    prdata_reg <= {24'h0, config_reg};
                else
                    prdata_reg <= 32'h0000_0000;
            end
            irq_reg <= |(flags & (adv ? irq_en_reg
                                      : leg_mask));
        end
    end

    // ------------------------------------------------------------
    // bus response
    // ------------------------------------------------------------
    // pslverr is raised from the setup cycle so that it stands
    // through the single access cycle of an unmapped address
    reg        pslverr_reg;
    reg        pready_reg;

    always @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pslverr_reg <= 1'b0;
            pready_reg  <= 1'b1;
        end
        else
        begin
            pslverr_reg <= I_PSEL & ~I_PENABLE & ~mapped;
            pready_reg  <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_PRDATA         = prdata_reg;
    assign O_PREADY         = pready_reg;
    assign O_PSLVERR        = pslverr_reg;
    assign O_TX_QUEUE_CLEAR = txclr_reg;
    assign O_RX_QUEUE_CLEAR = rxclr_reg;
    assign O_FIFO_ENABLE    = fifo_ctl_reg[`IRS_FC_FIFO_EN];
    // bit 3 is never stored without fifo enable, so it needs no gate
    assign O_DMA_MODE1      = fifo_ctl_reg[`IRS_FC_DMA_MODE];
    assign O_IRQ            = irq_reg;

endmodule // irs_status_fifo_ctrl

// [tb/irs_status_fifo_ctrl_monitor.sv]
// port assertions for the status / fifo control block
// assumes apb writes take effect at the access edge
`timescale 1ns/1ns

module irs_status_fifo_ctrl_monitor
(
    // clock and reset
    input wire        I_REF_CLK,
    input wire        I_RESETN,
    // apb
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [7:0]  I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    // fifo control
    input wire        O_TX_QUEUE_CLEAR,
    input wire        O_RX_QUEUE_CLEAR,
    input wire        O_FIFO_ENABLE,
    input wire        O_DMA_MODE1
);
    reg adv_reg;
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RESETN);
    // --------------------
    // mode tracking
    // --------------------
    always @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            adv_reg <= 1'b0;
        else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h20)
            adv_reg <= I_PWDATA[0];
    end
    sequence s_fc_wr;
        I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h08;
    endsequence
    sequence s_lg_rd;
        I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR == 8'h08 && !adv_reg;
    endsequence
    // --------------------
    // assertions
    // --------------------
    chk_txclr_pulse: assert property (
        s_fc_wr ##0 (I_PWDATA[2] && I_PWDATA[0])
        |=> O_TX_QUEUE_CLEAR ##1 !O_TX_QUEUE_CLEAR) else $error("tx clear");
    chk_rxclr_pulse: assert property (
        s_fc_wr ##0 (I_PWDATA[1] && I_PWDATA[0])
        |=> O_RX_QUEUE_CLEAR ##1 !O_RX_QUEUE_CLEAR) else $error("rx clear");
    chk_fifo_en_set: assert property (s_fc_wr
        |=> O_FIFO_ENABLE == $past(I_PWDATA[0])) else $error("fifo en");
    chk_dma_gate: assert property (O_DMA_MODE1 |-> O_FIFO_ENABLE)
        else $error("dma gate");
    chk_dma_write: assert property (s_fc_wr |=>
        O_DMA_MODE1 == $past(I_PWDATA[3] && I_PWDATA[0])) else $error("dma");
    chk_legacy_top: assert property (s_lg_rd
        |-> O_PRDATA[7:6] == {2{O_FIFO_ENABLE}}) else $error("bits 7:6");
    chk_legacy_zero: assert property (s_lg_rd
        |-> O_PRDATA[5:4] == 2'h0) else $error("bits 5:4");
    chk_legacy_bit3: assert property (s_lg_rd ##0 !O_FIFO_ENABLE
        |-> !O_PRDATA[3]) else $error("bit 3");
endmodule // irs_status_fifo_ctrl_monitor

bind irs_status_fifo_ctrl irs_status_fifo_ctrl_monitor
    irs_status_fifo_ctrl_monitor_i (.*);

// [tb/irs_dma_ctl_model.sv]
// model of the system dma controller terminal count line
// assumes the bench holds i_go for the length of a transfer
`timescale 1ns/1ns

module irs_dma_ctl_model
(
    // clock
    input  wire i_clk,
    // transfer from the bench
    input  wire i_go,
    // terminal count to the port
    output reg  o_tc
);
    // --------------------
    // terminal count
    // --------------------
    initial o_tc = 1'b0;
    always @(posedge i_clk)
        o_tc <= i_go;
endmodule // irs_dma_ctl_model

// [tb/irs_status_fifo_ctrl_tb.sv]
// self-checking bench for the status / fifo control block
// assumes design, monitor and dma model are compiled first
`timescale 1ns/1ns

module irs_status_fifo_ctrl_tb;
    reg         clk, rstn, psel, pen, pwr, go, se;
    reg  [7:0]  padr;
    reg  [31:0] pwd, r;
    reg  [8:0]  ev;
    reg  [5:0]  rxl, txl;
    reg  [3:0]  lv;
    wire [31:0] prd;
    wire        prdy, pslv, tc, fen, dm1, irq;
    integer     n_mismatch, checked, i, s;
    reg  [5:0]  rxt [0:7] = '{6'h01, 6'h04, 6'h08, 6'h0E,
                             6'h01, 6'h04, 6'h10, 6'h1A};
    reg  [5:0]  txt [0:7] = '{6'h01, 6'h03, 6'h09, 6'h0D,
                             6'h01, 6'h07, 6'h11, 6'h19};
    irs_status_fifo_ctrl irs_status_fifo_ctrl_i
    (
        .I_REF_CLK(clk), .I_RESETN(rstn), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
        .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
        .O_PSLVERR(pslv), .I_RX_LEVEL(rxl), .I_TX_LEVEL(txl),
        .I_TX_SHIFT_EMPTY(lv[0]), .I_CHAR_TICK(ev[0]),
        .I_RX_BUFFER_READ(ev[1]), .I_TX_BUFFER_WRITE(ev[2]),
        .I_LINE_STATUS_READ(ev[3]), .I_HANDSHAKE_STATUS_READ(ev[4]),
        .I_LINE_ERROR(ev[5]), .I_FRAME_END(ev[6]),
        .I_TIMER_ZERO(ev[7]), .I_TIMER_RUN(lv[1]),
        .I_FS_AT_THRESHOLD(lv[2]), .I_FS_TIMEOUT(lv[3]),
        .I_HANDSHAKE_TOGGLE(ev[8]), .I_DMA_TC(tc),
        .O_TX_QUEUE_CLEAR(), .O_RX_QUEUE_CLEAR(),
        .O_FIFO_ENABLE(fen), .O_DMA_MODE1(dm1), .O_IRQ(irq)
    );
    irs_dma_ctl_model irs_dma_ctl_model_i
    (
        .i_clk(clk), .i_go(go), .o_tc(tc)
    );
    // --------------------
    // tasks
    // --------------------
    task stop_test;
    begin
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task chk(input string nm, input [31:0] v, input [31:0] e);
    begin
        checked = checked + 1;
        if (v !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0s expected %h seen %h", nm, e, v);
        end
    end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
    begin
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        @(posedge clk);
        while (prdy !== 1'b1 && k < 20)
        begin
            k = k + 1;
            @(posedge clk);
        end
        r = prd;
        se = pslv;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k == 20)
        begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
        @(posedge clk);
    end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        apb(1'b1, a, {24'h000000, v});
    endtask
    task st(input [7:0] m, input [7:0] e);
    begin
        apb(1'b0, 8'h08, 32'h00000000);
        chk("status", r & {24'hFFFFFF, m}, {24'h000000, e});
    end
    endtask
    task pulse(input integer b);
    begin
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
        @(posedge clk);
    end
    endtask
    // --------------------
    // stimulus
    // --------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        {rstn, psel, pen, pwr, go, padr, pwd, ev} = 0;
        {rxl, txl, lv, n_mismatch, checked} = 0;
        lv[0] = 1'b1;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        wr(8'h04, 8'h07);
        @(posedge clk);
        chk("irq", irq, 1'b1);
        st(8'hFF, 8'h02);
        st(8'hFF, 8'h01);
        txl <= 6'h01;
        @(posedge clk);
        txl <= 6'h00;
        repeat (3) @(posedge clk);
        chk("irq", irq, 1'b1);
        pulse(2);
        st(8'hFF, 8'h01);
        rxl <= 6'h01;
        pulse(5);
        st(8'hFF, 8'h06);
        pulse(3);
        st(8'hFF, 8'h04);
        rxl <= 6'h00;
        pulse(1);
        st(8'hFF, 8'h01);
        wr(8'h08, 8'h01);
        chk("fifo_en", fen, 1'b1);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h08, {i[1:0], 6'h01});
            rxl <= rxt[i] - 6'h01;
            pulse(1);
            st(8'hFF, 8'hC1);
            rxl <= rxt[i];
            st(8'hFF, 8'hC4);
        end
        wr(8'h08, 8'h41);
        rxl <= 6'h01;
        pulse(1);
        repeat (3) pulse(0);
        st(8'hFF, 8'hC1);
        pulse(0);
        st(8'hFF, 8'hCC);
        rxl <= 6'h00;
        pulse(1);
        st(8'hFF, 8'hC1);
        wr(8'h08, 8'h0F);
        chk("dma_mode1", dm1, 1'b1);
        wr(8'h08, 8'h08);
        chk("dma_mode1", dm1, 1'b0);
        chk("fifo_en", fen, 1'b0);
        for (s = 0; s < 2; s = s + 1)
        begin
            wr(8'h20, {6'h00, s[0], 1'b1});
            wr(8'h08, 8'h01);
            for (i = 0; i < 4; i = i + 1)
            begin
                wr(8'h08, {i[1:0], i[1:0], 4'h1});
                rxl <= rxt[s * 4 + i] - 6'h01;
                txl <= txt[s * 4 + i] - 6'h01;
                pulse(1);
                st(8'h21, 8'h20);
                rxl <= rxt[s * 4 + i];
                txl <= txt[s * 4 + i] + 6'h01;
                st(8'h21, 8'h01);
            end
        end
        txl <= 6'h00;
        @(posedge clk);
        st(8'h02, 8'h02);
        st(8'h02, 8'h00);
        pulse(5);
        st(8'h04, 8'h04);
        pulse(3);
        st(8'h04, 8'h00);
        wr(8'h04, 8'h80);
        lv[1] <= 1'b1;
        pulse(7);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b1);
        st(8'h80, 8'h80);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b0);
        wr(8'h20, 8'h09);
        pulse(8);
        st(8'h08, 8'h08);
        pulse(4);
        st(8'h08, 8'h00);
        wr(8'h20, 8'h05);
        pulse(8);
        st(8'h08, 8'h00);
        pulse(6);
        st(8'h04, 8'h04);
        st(8'h04, 8'h00);
        lv[2] <= 1'b1;
        st(8'h40, 8'h40);
        lv[2] <= 1'b0;
        st(8'h40, 8'h00);
        go <= 1'b1;
        repeat (6) @(posedge clk);
        go <= 1'b0;
        st(8'h10, 8'h10);
        st(8'h10, 8'h00);
        apb(1'b0, 8'h3C, 32'h00000000);
        chk("unmapped", r, 32'h00000000);
        chk("slverr", se, 1'b1);
        stop_test;
    end
endmodule // irs_status_fifo_ctrl_tb
